// ### hw/identity_and_global_control.v
// identity registers, global control and fan duty selection
`timescale 1ns/1ns
`default_nettype none
`include "idgc_map.vh"
module identity_and_global_control #(
    parameter       N_PWM        = 3,
    parameter       AW           = 14,
    parameter       CNT_W        = 23,
    parameter       STARTUP_CYC  = `STARTUP_CYCLES,
    parameter [7:0] MAKER_CODE   = 8'ha5, // arbitrary value
    parameter [3:0] VERSION_NUM  = 4'h3,  // arbitrary value
    parameter [3:0] STEPPING_NUM = 4'h1   // arbitrary value
) (
    input  wire             i_ref_clk,
    input  wire             i_rst_n,
    input  wire [AW-1:0]    i_awaddr,
    input  wire [2:0]       i_awprot,
    input  wire             i_awvalid,
    output wire             o_awready,
    input  wire [31:0]      i_wdata,
    input  wire [3:0]       i_wstrb,
    input  wire             i_wvalid,
    output wire             o_wready,
    output reg  [1:0]       o_bresp,
    output reg              o_bvalid,
    input  wire             i_bready,
    input  wire [AW-1:0]    i_araddr,
    input  wire [2:0]       i_arprot,
    input  wire             i_arvalid,
    output wire             o_arready,
    output reg  [31:0]      o_rdata,
    output reg  [1:0]       o_rresp,
    output reg              o_rvalid,
    input  wire             i_rready,
    input  wire [7:0]       i_temp_sample,
    input  wire [15:0]      i_tach_count,
    output wire [N_PWM-1:0] o_pwm,
    output wire             o_monitor_active
);
    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;
    localparam [1:0] ST_IDLE     = 2'b00;
    localparam [1:0] ST_WARMUP   = 2'b01;
    localparam [1:0] ST_RUN      = 2'b10;

    // ****************************************
    // control and parameter state
    // ****************************************
    reg              start_q;
    reg              lock_q;
    reg              ready_q;
    reg              override_q;
    reg  [7:0]       limit_q;
    reg  [7:0]       auto_duty_q;
    reg  [N_PWM-1:0] manual_q;
    reg  [7:0]       temp_q;
    reg              alarm_q;
    reg  [1:0]       state_q;
    reg  [1:0]       state_d;
    reg  [CNT_W-1:0] warm_cnt_q;
    reg  [CNT_W-1:0] warm_cnt_d;
    wire [7:0]       cur_duty [0:N_PWM-1];

    // ****************************************
    // write channel capture
    // ****************************************
    reg  [AW-1:0]    awaddr_q;
    reg              aw_held_q;
    reg  [31:0]      wdata_q;
    reg  [3:0]       wstrb_q;
    reg              w_held_q;
    wire             aw_take;
    wire             w_take;
    wire             aw_have;
    wire             w_have;
    wire             do_write;
    wire [AW-1:0]    wr_addr;
    wire [31:0]      wr_data;
    wire [3:0]       wr_strb;
    wire             wr_lane0;
    wire             wr_open;

    assign o_awready = !aw_held_q && !o_bvalid;
    assign o_wready  = !w_held_q && !o_bvalid;
    assign aw_take   = i_awvalid && o_awready;
    assign w_take    = i_wvalid && o_wready;
    assign aw_have   = aw_held_q || aw_take;
    assign w_have    = w_held_q || w_take;
    assign do_write  = aw_have && w_have;
    assign wr_addr   = aw_held_q ? awaddr_q : i_awaddr;
    assign wr_data   = w_held_q ? wdata_q : i_wdata;
    assign wr_strb   = w_held_q ? wstrb_q : i_wstrb;
    assign wr_lane0  = do_write && wr_strb[0];
    assign wr_open   = wr_lane0 && !lock_q;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= {AW{1'b0}};
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end else begin
            if (aw_take)
                awaddr_q <= i_awaddr;
            if (w_take) begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            aw_held_q <= aw_have && !do_write;
            w_held_q  <= w_have && !do_write;
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp  <= rd_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    function rd_mapped;
        input [AW-1:0] a;
        begin
            rd_mapped = (a == `ADDR_OF(`IDX_MAKER_CODE))
                     || (a == `ADDR_OF(`IDX_DEVICE_REV))
                     || (a == `ADDR_OF(`IDX_GLOBAL_CTRL))
                     || (a == `ADDR_LIMIT) || (a == `ADDR_AUTO_DUTY)
                     || (a == `ADDR_FAN_MODE) || (a == `ADDR_MON_STATUS)
                     || (a == `ADDR_TEMP_READ) || (a == `ADDR_TACH_READ)
                     || (a >= `ADDR_DUTY_BASE
                         && a < `ADDR_DUTY_BASE + N_PWM * 4
                         && a[1:0] == 2'b00);
        end
    endfunction

    // ****************************************
    // global control register
    // ****************************************
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_q    <= 1'b0;
            lock_q     <= 1'b0;
            override_q <= 1'b0;
            ready_q    <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            if (wr_lane0 && wr_addr == `ADDR_OF(`IDX_GLOBAL_CTRL)) begin
                start_q    <= wr_data[`CTRL_START];
                override_q <= wr_data[`CTRL_OVERRIDE];
                if (wr_data[`CTRL_LOCK])
                    lock_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // limit and parameter registers
    // ****************************************
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            limit_q     <= `DEFAULT_LIMIT;
            auto_duty_q <= `DEFAULT_AUTO_DUTY;
            manual_q    <= {N_PWM{1'b0}};
        end else begin
            // kept across start changes
            if (wr_open && wr_addr == `ADDR_LIMIT)
                limit_q <= wr_data[7:0];
            if (wr_open && wr_addr == `ADDR_AUTO_DUTY)
                auto_duty_q <= wr_data[7:0];
            if (wr_open && wr_addr == `ADDR_FAN_MODE)
                manual_q <= wr_data[N_PWM-1:0];
        end
    end

    // ****************************************
    // monitoring start-up sequencer
    // ****************************************
    always @* begin
        state_d    = state_q;
        warm_cnt_d = warm_cnt_q;
        case (state_q)
            ST_IDLE: begin
                warm_cnt_d = {CNT_W{1'b0}};
                if (start_q) begin
                    state_d = ST_WARMUP;
                end
            end
            ST_WARMUP: begin
                warm_cnt_d = warm_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                if (!start_q) begin
                    state_d = ST_IDLE;
                end else if (warm_cnt_q == STARTUP_CYC[CNT_W-1:0] - 1'b1) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!start_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q    <= ST_IDLE;
            warm_cnt_q <= {CNT_W{1'b0}};
        end else begin
            state_q    <= state_d;
            warm_cnt_q <= warm_cnt_d;
        end
    end

    assign o_monitor_active = (state_q == ST_RUN);

    // ****************************************
    // temperature reading and alarm status
    // ****************************************
    wire [7:0] eff_limit;
    wire       over_limit;
    wire       alarm_clr;

    assign eff_limit  = start_q ? limit_q : `DEFAULT_LIMIT;
    assign over_limit = temp_q > eff_limit;
    assign alarm_clr  = wr_lane0 && wr_addr == `ADDR_MON_STATUS
                        && wr_data[`STAT_ALARM];

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            temp_q  <= 8'h00;
            alarm_q <= 1'b0;
        end else begin
            if (o_monitor_active)
                temp_q <= i_temp_sample;
            if (o_monitor_active && start_q && over_limit) begin
                alarm_q <= 1'b1;
            end else if (alarm_clr) begin
                alarm_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // per-channel duty select and pwm
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N_PWM; g = g + 1) begin : g_pwm
            reg  [7:0]    duty_sel;
            reg  [7:0]    duty_q;
            wire [31:0]   duty_addr;

            assign duty_addr = `ADDR_DUTY_BASE + g * 4;

            always @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    duty_q <= `FULL_DUTY;
                end else if (wr_open && start_q && manual_q[g]
                             && wr_addr == duty_addr[AW-1:0]) begin
                    duty_q <= wr_data[7:0];
                end
            end

            always @* begin
                if (override_q) begin
                    duty_sel = `FULL_DUTY;
                end else if (!start_q) begin
                    duty_sel = `FULL_DUTY;
                end else if (manual_q[g]) begin
                    duty_sel = duty_q;
                end else if (o_monitor_active && over_limit) begin
                    duty_sel = `FULL_DUTY;
                end else begin
                    duty_sel = auto_duty_q;
                end
            end

            pwm_channel u_pwm (
                .i_ref_clk  (i_ref_clk),
                .i_rst_n    (i_rst_n),
                .i_duty     (duty_sel),
                .o_cur_duty (cur_duty[g]),
                .o_pwm      (o_pwm[g])
            );
        end
    endgenerate

    // ****************************************
    // read channel
    // ****************************************
    reg  [31:0] rd_word;
    integer     k;

    assign o_arready = !o_rvalid;

    always @* begin
        rd_word = 32'h00000000;
        case (i_araddr)
            `ADDR_OF(`IDX_MAKER_CODE): begin
                rd_word[7:0] = MAKER_CODE;
            end
            `ADDR_OF(`IDX_DEVICE_REV): begin
                rd_word[7:0] = {VERSION_NUM, STEPPING_NUM};
            end
            `ADDR_OF(`IDX_GLOBAL_CTRL): begin
                // upper bits stay zero
                rd_word[`CTRL_START]    = start_q;
                rd_word[`CTRL_LOCK]     = lock_q;
                rd_word[`CTRL_READY]    = ready_q;
                rd_word[`CTRL_OVERRIDE] = override_q;
            end
            `ADDR_LIMIT: begin
                rd_word[7:0] = limit_q;
            end
            `ADDR_AUTO_DUTY: begin
                rd_word[7:0] = auto_duty_q;
            end
            `ADDR_FAN_MODE: begin
                rd_word[N_PWM-1:0] = manual_q;
            end
            `ADDR_MON_STATUS: begin
                rd_word[`STAT_ACTIVE] = o_monitor_active;
                rd_word[`STAT_ALARM]  = alarm_q;
            end
            `ADDR_TEMP_READ: begin
                rd_word[7:0] = temp_q;
            end
            `ADDR_TACH_READ: begin
                rd_word[15:0] = i_tach_count;
            end
            default: begin
                for (k = 0; k < N_PWM; k = k + 1) begin
                    if (i_araddr == `ADDR_DUTY_BASE + k * 4)
                        rd_word[7:0] = cur_duty[k];
                end
            end
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h00000000;
            o_rresp  <= RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_word;
                o_rresp  <= rd_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule // identity_and_global_control
`default_nettype wire

// ### hw/pwm_channel.v
// one pwm output with a 256-clock period
`timescale 1ns/1ns
`default_nettype none
module pwm_channel (
    input  wire       i_ref_clk,
    input  wire       i_rst_n,
    input  wire [7:0] i_duty,
    output reg  [7:0] o_cur_duty,
    output reg        o_pwm
);
    reg [7:0] cnt_q;

    // ****************************************
    // period counter, duty taken at period start
    // ****************************************
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q      <= 8'h00;
            o_cur_duty <= 8'hff;
            o_pwm      <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'hff) begin
                o_cur_duty <= i_duty;
            end
            // full duty: high 255, low 1
            o_pwm <= (cnt_q + 8'h01) < o_cur_duty;
            if (cnt_q == 8'hff) begin
                o_pwm <= 8'h00 < i_duty;
            end
        end
    end
endmodule // pwm_channel
`default_nettype wire

// ### pkg/idgc_map.vh
// register map, field positions, reset values and timing counts
`ifndef IDGC_MAP_VH
`define IDGC_MAP_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define IDX_MAKER_CODE     12'h03e
`define IDX_DEVICE_REV     12'h03f
`define IDX_GLOBAL_CTRL    12'h040
`define ADDR_OF(idx)       ({(idx), 2'b00})
`define ADDR_LIMIT         14'h0104
`define ADDR_AUTO_DUTY     14'h0108
`define ADDR_FAN_MODE      14'h010c
`define ADDR_MON_STATUS    14'h0110
`define ADDR_TEMP_READ     14'h0114
`define ADDR_TACH_READ     14'h0118
`define ADDR_DUTY_BASE     14'h0120

// ****************************************
// control fields and reset values
// ****************************************
`define CTRL_START         0
`define CTRL_LOCK          1
`define CTRL_READY         2
`define CTRL_OVERRIDE      3
`define CTRL_RESET         4'h0
`define STAT_ACTIVE        0
`define STAT_ALARM         1
`define DEFAULT_LIMIT      8'h46
`define DEFAULT_AUTO_DUTY  8'h80
`define FULL_DUTY          8'hff

// ****************************************
// timing
// ****************************************
`define CLK_KHZ            100000
`define STARTUP_MS         82
`define STARTUP_CYCLES     (`STARTUP_MS * `CLK_KHZ)

`endif

// ### verif/identity_and_global_control_monitor.sv
// checker and bind for identity and global control
`timescale 1ns/1ns
`default_nettype none
module identity_and_global_control_monitor #(
    parameter       N_PWM       = 3,
    parameter       AW          = 14,
    parameter       STARTUP_CYC = 20,
    parameter [7:0] MAKER_CODE  = 8'ha5
) (
    input wire logic             i_ref_clk,
    input wire logic             i_rst_n,
    input wire logic [AW-1:0]    i_awaddr,
    input wire logic             i_awvalid,
    input wire logic             o_awready,
    input wire logic [31:0]      i_wdata,
    input wire logic [3:0]       i_wstrb,
    input wire logic             i_wvalid,
    input wire logic             o_wready,
    input wire logic [AW-1:0]    i_araddr,
    input wire logic             i_arvalid,
    input wire logic             o_arready,
    input wire logic [31:0]      o_rdata,
    input wire logic [1:0]       o_rresp,
    input wire logic             o_rvalid,
    input wire logic             i_rready,
    input wire logic [N_PWM-1:0] o_pwm,
    input wire logic             o_monitor_active
);
    // ********
    // shadow of control bits
    // ********
    logic          start_q;
    logic          ovr_q;
    logic [9:0]    full_cnt_q;
    int            run_cnt_q;
    logic [AW-1:0] raddr_q;
    wire           full = !start_q || ovr_q;
    wire           ctrl_wr = i_awvalid && o_awready && i_wvalid && o_wready
                             && i_wstrb[0] && i_awaddr == 14'h100;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_q    <= 1'b0;
            ovr_q      <= 1'b0;
            full_cnt_q <= 10'h000;
            run_cnt_q  <= 0;
            raddr_q    <= {AW{1'b0}};
        end else begin
            if (ctrl_wr) begin
                start_q <= i_wdata[0];
                ovr_q   <= i_wdata[3];
            end
            if (i_arvalid && o_arready) raddr_q <= i_araddr;
            full_cnt_q <= !full ? 10'h000 : full_cnt_q + {9'h000, full_cnt_q != 10'h3ff};
            run_cnt_q  <= !start_q ? 0 : run_cnt_q + (run_cnt_q < 100000 ? 1 : 0);
        end
    end

    // ********
    // assertions
    // ********
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_maker_read: assert property (o_rvalid && raddr_q == 14'h0f8
        |-> o_rdata == {24'h000000, MAKER_CODE} && o_rresp == 2'b00)
        else $error("maker code read wrong");
    a_ctrl_read: assert property (o_rvalid && raddr_q == 14'h100
        |-> o_rdata[31:4] == 28'h0000000 && o_rdata[2] && o_rdata[0] == start_q
            && o_rdata[3] == ovr_q)
        else $error("control read wrong");
    a_full_high: assert property (full_cnt_q > 10'd512
        |-> &(o_pwm | $past(o_pwm)))
        else $error("pwm low twice in a row at full duty");
    a_full_low_pulse: assert property (full_cnt_q > 10'd512 && o_pwm[0]
        |-> ##[1:256] !o_pwm[0])
        else $error("pwm never low in a period");
    a_no_idle_monitor: assert property (!start_q |=> !o_monitor_active)
        else $error("monitoring while start clear");
    a_warmup_length: assert property ($rose(o_monitor_active)
        |-> run_cnt_q >= STARTUP_CYC - 2 && run_cnt_q <= STARTUP_CYC + 2)
        else $error("warm-up length wrong");
    a_warmup_bound: assert property (run_cnt_q == STARTUP_CYC + 3 |-> o_monitor_active)
        else $error("monitoring not running after warm-up");
    a_idle_status: assert property (o_rvalid && raddr_q == 14'h110 && !start_q
        |-> !o_rdata[0])
        else $error("status active while start clear");
    a_rdata_stands: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read answer dropped early");

    c_warm: cover property ($rose(o_monitor_active));
    c_lock: cover property (ctrl_wr && i_wdata[1]);
    c_slverr: cover property (o_rvalid && o_rresp == 2'b10);
endmodule // identity_and_global_control_monitor

bind identity_and_global_control identity_and_global_control_monitor #(
    .N_PWM(N_PWM), .AW(AW), .STARTUP_CYC(STARTUP_CYC), .MAKER_CODE(MAKER_CODE)
) i_mon (
    .i_ref_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_pwm, .o_monitor_active
);
`default_nettype wire

// ### verif/identity_and_global_control_tb.sv
// self-checking bench for identity and global control
`timescale 1ns/1ns
`default_nettype none
`include "idgc_map.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module identity_and_global_control_tb;
    localparam int    SU    = 20;
    localparam [7:0]  MK    = 8'h3c; // arbitrary value
    localparam [3:0]  VER   = 4'h2;  // arbitrary value
    localparam [3:0]  STP   = 4'h7;  // arbitrary value
    localparam [13:0] A_MK  = `ADDR_OF(`IDX_MAKER_CODE);
    localparam [13:0] A_RV  = `ADDR_OF(`IDX_DEVICE_REV);
    localparam [13:0] A_CT  = `ADDR_OF(`IDX_GLOBAL_CTRL);
    localparam [13:0] A_LIM = `ADDR_LIMIT;
    localparam [13:0] A_DTY = `ADDR_DUTY_BASE;
    logic        i_ref_clk = 1'b0, i_rst_n = 1'b0;
    logic [13:0] i_awaddr = 14'h0000, i_araddr = 14'h0000;
    logic [2:0]  i_awprot = 3'h0, i_arprot = 3'h0;
    logic [31:0] i_wdata = 32'h00000000;
    logic [3:0]  i_wstrb = 4'h0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0]  i_temp_sample = 8'h48;
    logic [15:0] i_tach_count = 16'h0055;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_monitor_active;
    wire [1:0]   o_bresp, o_rresp;
    wire [31:0]  o_rdata;
    wire [2:0]   o_pwm;
    int          n_fail = 0, checks = 0, cyc = 0, n;
    logic [31:0] d, d0;
    logic [1:0]  r, br;

    identity_and_global_control #(
        .STARTUP_CYC(SU), .MAKER_CODE(MK), .VERSION_NUM(VER), .STEPPING_NUM(STP)
    ) i_dut (
        .i_ref_clk, .i_rst_n, .i_awaddr, .i_awprot, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arprot, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .i_temp_sample, .i_tach_count, .o_pwm, .o_monitor_active
    );

    initial forever #5 i_ref_clk = ~i_ref_clk;

    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    // ********
    // bus and helper tasks
    // ********
    task automatic wr(input [13:0] a, input [31:0] v, input [3:0] s = 4'hf);
        logic aw, w, awd, wd;
        awd = 1'b0;
        wd = 1'b0;
        @(posedge i_ref_clk);
        i_awaddr <= a;
        i_wdata <= v;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(awd && wd)) begin
            @(negedge i_ref_clk);
            aw = i_awvalid && o_awready;
            w = i_wvalid && o_wready;
            @(posedge i_ref_clk);
            if (aw) begin
                awd = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (w) begin
                wd = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do begin
            @(negedge i_ref_clk);
            aw = o_bvalid;
            br = o_bresp;
            @(posedge i_ref_clk);
        end while (!aw);
        i_bready <= 1'b0;
    endtask

    task automatic rd(input [13:0] a, output [31:0] v, output [1:0] rs);
        logic h;
        @(posedge i_ref_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(negedge i_ref_clk);
            h = o_arready;
            @(posedge i_ref_clk);
        end while (!h);
        i_arvalid <= 1'b0;
        do begin
            @(negedge i_ref_clk);
            h = o_rvalid;
            v = o_rdata;
            rs = o_rresp;
            @(posedge i_ref_clk);
        end while (!h);
        i_rready <= 1'b0;
    endtask

    task cr(input [13:0] a, input [31:0] e);
        rd(a, d, r);
        `CHK("read data", e, d)
    endtask

    task pwm_hi(input int ch, input int e);
        repeat (600) @(posedge i_ref_clk);
        n = 0;
        repeat (256) begin
            @(negedge i_ref_clk);
            n += (o_pwm[ch] === 1'b1);
        end
        `CHK("pwm high clocks", e, n)
    endtask

    // ********
    // scenarios
    // ********
    task t_ident;
        cr(A_MK, {24'h000000, MK});
        cr(A_RV, {24'h000000, VER, STP});
        cr(A_CT, 32'h00000004);
        wr(A_MK, 32'h000000ff);
        `CHK("ro write resp", 2'b00, br)
        wr(A_RV, 32'h00000000);
        wr(A_CT, 32'h000000f0);
        cr(A_MK, {24'h000000, MK});
        cr(A_RV, {24'h000000, VER, STP});
        cr(A_CT, 32'h00000004);
        rd(14'h0200, d, r);
        `CHK("unmapped resp", 2'b10, r)
        wr(14'h0200, 32'h00000000);
        `CHK("unmapped wr resp", 2'b10, br)
    endtask

    task t_idle;
        for (int ch = 0; ch < 3; ch++) pwm_hi(ch, 255);
        rd(`ADDR_MON_STATUS, d, r);
        `CHK("idle status", 2'b00, d[1:0])
        rd(`ADDR_TEMP_READ, d0, r);
        i_temp_sample <= 8'h11;
        rd(`ADDR_TEMP_READ, d, r);
        `CHK("idle temp", d0, d)
        rd(`ADDR_TACH_READ, d, r);
        `CHK("tach", 8'h55, d[7:0])
        wr(`ADDR_FAN_MODE, 32'h00000001);
        wr(A_DTY, 32'h00000040);
        pwm_hi(0, 255);
        cr(A_DTY, 32'h000000ff);
    endtask

    task t_run;
        i_temp_sample <= 8'h48;
        wr(A_LIM, 32'h00000050);
        wr(A_CT, 32'h00000001);
        n = 0;
        while (o_monitor_active !== 1'b1 && n < 200) begin
            @(negedge i_ref_clk);
            n++;
        end
        `CHK("warm-up", 1'b1, n >= SU - 4 && n <= SU + 2)
        repeat (10) @(posedge i_ref_clk);
        rd(`ADDR_MON_STATUS, d, r);
        `CHK("alarm above default", 1'b0, d[1])
        cr(`ADDR_TEMP_READ, 32'h00000048);
        wr(A_LIM, 32'h00000040);
        cr(A_LIM, 32'h00000040);
        repeat (10) @(posedge i_ref_clk);
        rd(`ADDR_MON_STATUS, d, r);
        `CHK("alarm", 1'b1, d[1])
        wr(A_DTY, 32'h00000040);
        pwm_hi(0, 64);
        cr(A_DTY, 32'h00000040);
        wr(A_CT, 32'h00000009);
        pwm_hi(0, 255);
        wr(A_CT, 32'h00000000);
        cr(A_LIM, 32'h00000040);
        `CHK("monitor off", 1'b0, o_monitor_active)
        pwm_hi(1, 255);
    endtask

    task t_lock;
        wr(A_CT, 32'h00000003);
        cr(A_CT, 32'h00000007);
        wr(A_LIM, 32'h00000022);
        wr(A_DTY, 32'h00000010);
        cr(A_LIM, 32'h00000040);
        pwm_hi(0, 64);
        wr(A_CT, 32'h00000000);
        cr(A_CT, 32'h00000006);
        wr(A_CT, 32'h00000009);
        cr(A_CT, 32'h0000000f);
        pwm_hi(0, 255);
        wr(A_CT, 32'h00000000, 4'he);
        cr(A_CT, 32'h0000000f);
    endtask

    task t_reset;
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        cr(A_CT, 32'h00000004);
        wr(A_LIM, 32'h00000033);
        cr(A_LIM, 32'h00000033);
    endtask

    task end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_ident();
        t_idle();
        t_run();
        t_lock();
        t_reset();
        end_sim();
    end
endmodule // identity_and_global_control_tb
`default_nettype wire
